/* File: core/sbr_core.sv */
`timescale 1ns/10ps
module sbr_core
  import sbr_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]    address,
  input  wire logic [3:0]    byteenable,
  input  wire logic          read,
  input  wire logic          write,
  input  wire logic [31:0]   writedata,
  output logic [31:0]        readdata,
  output logic               waitrequest,
  // Flag set pulses from the shift engine
  input  wire sbr_flags_type flagSet,
  // Flag state to the shift engine
  output sbr_flags_type      flags,
  // Rate enables
  output logic               baseClockTick,
  output logic               bitTick,
  // Interrupt requests
  output logic [3:0]         irqRequest,
  output logic               irq
);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic [2:0]       mode_q;
  logic [1:0]       ext_q;
  logic [7:0]       divider_q;
  logic [3:0]       ctrl_q;
  sbr_flags_type    flags_q;
  sbr_flags_type    flags_d;
  logic [2:0]       armed_q;
  logic [3:0]       icuReq_q;
  logic [3:0]       icuReq_d;
  logic [3:0]       icuEn_q;
  logic [3:0]       srcPrev_q;
  logic [3:0]       srcLvl;
  logic [3:0]       srcRise;
  logic [3:0]       irqLines_q;
  logic             irq_q;
  logic             waitReq_q;
  logic [31:0]      readData_q;
  logic [31:0]      rdMux;
  logic             genHalf_q;
  logic [3:0]       bitCnt_q;
  logic             bitTick_q;
  logic             baseClkTick_q;
  logic             baseTick;
  logic             genTick;
  logic             stepTick;
  logic [3:0]       stepLast;
  logic             busReq;
  logic             accept;
  logic             wrEn;
  logic             rdAccept;
  logic             errAny;
  sbr_rate_cfg_type cfg;

  // Settings view
  assign cfg.asyncMode         = mode_q[MODE_ASYNC_BIT];
  assign cfg.prescaleExp       = {mode_q[MODE_PRESCALE_HIGH_BIT], mode_q[MODE_PRESCALE_LOW_BIT]};
  assign cfg.doubleSpeedSelect = ext_q[EXT_DOUBLE_SPEED_BIT];
  assign cfg.baseClockSelect   = ext_q[EXT_BASE_CLOCK_BIT];
  assign cfg.divider           = divider_q;

  // Bus handshake terms
  assign busReq   = read | write;
  assign accept   = busReq && !waitReq_q;
  assign wrEn     = write && accept && byteenable[0];
  assign rdAccept = read && accept;

  // Waitrequest drops one cycle after a request appears
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitReq_q <= 1'b1;
    end else if (accept) begin
      waitReq_q <= 1'b1;
    end else if (busReq) begin
      waitReq_q <= 1'b0;
    end
  end

  // Read multiplexer, unmapped reads as zero
  always_comb begin
    rdMux = 32'h0000_0000;
    case (address)
      ADDR_SERIAL_MODE_REG:    rdMux[2:0] = mode_q;
      ADDR_EXTENDED_MODE_REG:  rdMux[1:0] = ext_q;
      ADDR_BIT_RATE_DIVIDER:   rdMux[7:0] = divider_q;
      ADDR_SERIAL_CONTROL_REG: rdMux[3:0] = ctrl_q;
      ADDR_SERIAL_STATUS_REG:  rdMux[5:0] = flags_q;
      ADDR_ICU_REQUEST_FLAG:   rdMux[3:0] = icuReq_q;
      ADDR_ICU_SOURCE_ENABLE:  rdMux[3:0] = icuEn_q;
      default:                 rdMux = 32'h0000_0000;
    endcase
  end

  // Read data captured while waitrequest is high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      readData_q <= 32'h0000_0000;
    end else if (read && waitReq_q) begin
      readData_q <= rdMux;
    end
  end

  // Mode, divider and control registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q    <= MODE_RESET;
      ext_q     <= EXT_RESET;
      divider_q <= DIVIDER_RESET;
      ctrl_q    <= CTRL_RESET;
      icuEn_q   <= ICU_RESET;
    end else if (wrEn) begin
      case (address)
        ADDR_SERIAL_MODE_REG:    mode_q    <= writedata[2:0];
        ADDR_EXTENDED_MODE_REG:  ext_q     <= writedata[1:0];
        ADDR_BIT_RATE_DIVIDER:   divider_q <= writedata[7:0];
        ADDR_SERIAL_CONTROL_REG: ctrl_q    <= writedata[3:0];
        ADDR_ICU_SOURCE_ENABLE:  icuEn_q   <= writedata[3:0];
        default:                 ctrl_q    <= ctrl_q;
      endcase
    end
  end

  // Status flags: set wins, errors need a prior read of one
  always_comb begin
    flags_d = flags_q;
    if (wrEn && address == ADDR_SERIAL_STATUS_REG) begin
      for (int i = 0; i < 3; i++) begin
        if (!writedata[i] && armed_q[i]) begin
          flags_d[i] = 1'b0;
        end
      end
      for (int i = 3; i < 6; i++) begin
        if (!writedata[i]) begin
          flags_d[i] = 1'b0;
        end
      end
    end
    flags_d = flags_d | flagSet;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Arming on a read that returned one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 3'h0;
    end else if (wrEn && address == ADDR_SERIAL_STATUS_REG) begin
      armed_q <= 3'h0;
    end else if (rdAccept && address == ADDR_SERIAL_STATUS_REG) begin
      armed_q <= armed_q | readData_q[2:0];
    end
  end

  // Source levels from flags and local enables
  assign errAny = flags_q.overrunErrorFlag | flags_q.framingErrorFlag |
                  flags_q.parityErrorFlag;
  assign srcLvl[IRQ_ERR]      = errAny && ctrl_q[CTRL_RX_ERR_IE_BIT];
  assign srcLvl[IRQ_RX_FULL]  = flags_q.receiveBufferFullFlag &&
                                ctrl_q[CTRL_RX_ERR_IE_BIT];
  assign srcLvl[IRQ_TX_EMPTY] = flags_q.transmitBufferEmptyFlag &&
                                ctrl_q[CTRL_TX_EMPTY_IE_BIT];
  assign srcLvl[IRQ_TX_END]   = flags_q.transmitEndFlag &&
                                ctrl_q[CTRL_TX_END_IE_BIT];
  assign srcRise = srcLvl & ~srcPrev_q;

  // Controller request flags, write one clears, set wins
  always_comb begin
    icuReq_d = icuReq_q;
    if (wrEn && address == ADDR_ICU_REQUEST_FLAG) begin
      icuReq_d = icuReq_q & ~writedata[3:0];
    end
    icuReq_d = icuReq_d | srcRise;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      srcPrev_q <= 4'h0;
      icuReq_q  <= ICU_RESET;
    end else begin
      srcPrev_q <= srcLvl;
      icuReq_q  <= icuReq_d;
    end
  end

  // Gated request lines for the acceptance logic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqLines_q <= 4'h0;
      irq_q      <= 1'b0;
    end else begin
      irqLines_q <= icuReq_q & icuEn_q;
      irq_q      <= |(icuReq_q & icuEn_q);
    end
  end

  // Prescaler and divider
  sbr_rate_counter u_rate (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .runEnable   (ctrl_q[CTRL_RUN_BIT]),
    .prescaleExp (cfg.prescaleExp),
    .divider     (cfg.divider),
    .baseTick    (baseTick)
  );

  // Double speed passes every base pulse, else every second
  assign genTick  = baseTick && (cfg.doubleSpeedSelect || genHalf_q);
  assign stepTick = cfg.asyncMode ? genTick : baseTick;
  assign stepLast = !cfg.asyncMode ? SYNC_STEP_LAST :
                    (cfg.baseClockSelect ? ASYNC_STEP_LAST8 : ASYNC_STEP_LAST16);

  // Half-rate phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      genHalf_q <= 1'b0;
    end else if (!ctrl_q[CTRL_RUN_BIT]) begin
      genHalf_q <= 1'b0;
    end else if (baseTick) begin
      genHalf_q <= !genHalf_q;
    end
  end

  // Steps per bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_q <= 4'h0;
    end else if (!ctrl_q[CTRL_RUN_BIT]) begin
      bitCnt_q <= 4'h0;
    end else if (stepTick) begin
      if (bitCnt_q >= stepLast) begin
        bitCnt_q <= 4'h0;
      end else begin
        bitCnt_q <= 4'(bitCnt_q + 4'h1);
      end
    end
  end

  // Registered rate pulses
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bitTick_q     <= 1'b0;
      baseClkTick_q <= 1'b0;
    end else begin
      bitTick_q     <= stepTick && (bitCnt_q >= stepLast);
      baseClkTick_q <= stepTick;
    end
  end

  // Outputs
  assign readdata      = readData_q;
  assign waitrequest   = waitReq_q;
  assign flags         = flags_q;
  assign baseClockTick = baseClkTick_q;
  assign bitTick       = bitTick_q;
  assign irqRequest    = irqLines_q;
  assign irq           = irq_q;

  // Checking helpers: gaps and ticks since last setting write
  logic        cfgWrite;
  logic [23:0] gapBase_q;
  logic [23:0] gapBit_q;
  logic [1:0]  seenBase_q;
  logic [1:0]  seenBit_q;
  logic [23:0] expBase;
  logic [23:0] onePres;
  logic        stsZeroWr;

  assign cfgWrite = wrEn && (address == ADDR_SERIAL_MODE_REG ||
                    address == ADDR_EXTENDED_MODE_REG ||
                    address == ADDR_BIT_RATE_DIVIDER ||
                    address == ADDR_SERIAL_CONTROL_REG);
  assign onePres  = 24'h00_0001 << {cfg.prescaleExp, 1'b0};
  assign expBase  = 24'(onePres * (24'(cfg.divider) + 24'h00_0001));
  assign stsZeroWr = wrEn && address == ADDR_SERIAL_STATUS_REG && !writedata[0];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gapBase_q  <= 24'h00_0000;
      gapBit_q   <= 24'h00_0000;
      seenBase_q <= 2'h0;
      seenBit_q  <= 2'h0;
    end else begin
      gapBase_q <= baseTick ? 24'h00_0001 : 24'(gapBase_q + 24'h00_0001);
      gapBit_q  <= bitTick_q ? 24'h00_0001 : 24'(gapBit_q + 24'h00_0001);
      if (cfgWrite || !ctrl_q[CTRL_RUN_BIT]) begin
        seenBase_q <= 2'h0;
        seenBit_q  <= 2'h0;
      end else begin
        if (baseTick && seenBase_q != 2'h3) begin
          seenBase_q <= 2'(seenBase_q + 2'h1);
        end
        if (bitTick_q && seenBit_q != 2'h3) begin
          seenBit_q <= 2'(seenBit_q + 2'h1);
        end
      end
    end
  end

  sequence sBitSteady;
    bitTick_q && seenBit_q >= 2'h2 && !cfgWrite;
  endsequence

  sequence sErrRise;
    $rose(errAny) && ctrl_q[CTRL_RX_ERR_IE_BIT];
  endsequence

  a_base_period: assert property (
    baseTick && seenBase_q >= 2'h2 && !cfgWrite |-> gapBase_q == expBase)
    else $error("base pulse spacing wrong");

  a_sync_rate: assert property (
    sBitSteady ##0 !cfg.asyncMode |-> gapBit_q == 24'(expBase << 2))
    else $error("sync bit spacing wrong");

  a_async_normal: assert property (
    sBitSteady ##0 cfg.asyncMode && !cfg.doubleSpeedSelect && !cfg.baseClockSelect
    |-> gapBit_q == 24'(expBase << 5))
    else $error("async normal spacing wrong");

  a_async_single: assert property (
    sBitSteady ##0 cfg.asyncMode && (cfg.doubleSpeedSelect ^ cfg.baseClockSelect)
    |-> gapBit_q == 24'(expBase << 4))
    else $error("async single select spacing wrong");

  a_async_both: assert property (
    sBitSteady ##0 cfg.asyncMode && cfg.doubleSpeedSelect && cfg.baseClockSelect
    |-> gapBit_q == 24'(expBase << 3))
    else $error("async both select spacing wrong");

  a_double_speed: assert property (
    cfg.asyncMode && cfg.doubleSpeedSelect && baseTick && !cfgWrite
    |=> baseClockTick ##1 !baseClockTick)
    else $error("double speed pulse missing");

  a_step_count: assert property (
    cfg.asyncMode && stepTick && bitCnt_q == stepLast && !cfgWrite |=> bitTick)
    else $error("bit end not after last step");

  a_err_request: assert property (
    sErrRise |=> icuReq_q[IRQ_ERR])
    else $error("error request not raised");

  a_rx_gate: assert property (
    !ctrl_q[CTRL_RX_ERR_IE_BIT] && !icuReq_q[IRQ_RX_FULL] && !cfgWrite
    |=> !icuReq_q[IRQ_RX_FULL] && !icuReq_q[IRQ_ERR] || $past(icuReq_q[IRQ_ERR]))
    else $error("receive request without enable");

  a_icu_set: assert property (
    srcRise != 4'h0 |=> (icuReq_q & $past(srcRise)) == $past(srcRise))
    else $error("request flag lost");

  a_irq_level: assert property (
    (icuReq_q & icuEn_q) != 4'h0 |=> irq && irqRequest != 4'h0)
    else $error("interrupt output not raised");

  a_err_guard: assert property (
    stsZeroWr && !armed_q[0] && flags_q.overrunErrorFlag |=> flags.overrunErrorFlag)
    else $error("overrun cleared without read");

  a_bus_answer: assert property (
    busReq && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");

endmodule

/* File: include/sbr_pkg.sv */
package sbr_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [4:0] ADDR_SERIAL_MODE_REG    = 5'h00;
  localparam logic [4:0] ADDR_EXTENDED_MODE_REG  = 5'h04;
  localparam logic [4:0] ADDR_BIT_RATE_DIVIDER   = 5'h08;
  localparam logic [4:0] ADDR_SERIAL_CONTROL_REG = 5'h0C;
  localparam logic [4:0] ADDR_SERIAL_STATUS_REG  = 5'h10;
  localparam logic [4:0] ADDR_ICU_REQUEST_FLAG   = 5'h14;
  localparam logic [4:0] ADDR_ICU_SOURCE_ENABLE  = 5'h18;

  // Field positions
  localparam int MODE_PRESCALE_LOW_BIT  = 0;
  localparam int MODE_PRESCALE_HIGH_BIT = 1;
  localparam int MODE_ASYNC_BIT         = 2;
  localparam int EXT_DOUBLE_SPEED_BIT   = 0;
  localparam int EXT_BASE_CLOCK_BIT     = 1;
  localparam int CTRL_RX_ERR_IE_BIT     = 0;
  localparam int CTRL_TX_EMPTY_IE_BIT   = 1;
  localparam int CTRL_TX_END_IE_BIT     = 2;
  localparam int CTRL_RUN_BIT           = 3;

  // Request indices and their controller vector numbers
  localparam int IRQ_ERR     = 0;
  localparam int IRQ_RX_FULL = 1;
  localparam int IRQ_TX_EMPTY = 2;
  localparam int IRQ_TX_END  = 3;
  localparam int VECTOR_ERR      = 214;
  localparam int VECTOR_RX_FULL  = 215;
  localparam int VECTOR_TX_EMPTY = 216;
  localparam int VECTOR_TX_END   = 217;

  // Reset values
  localparam logic [2:0] MODE_RESET    = 3'h0;
  localparam logic [1:0] EXT_RESET     = 2'h0;
  localparam logic [7:0] DIVIDER_RESET = 8'hFF;
  localparam logic [3:0] CTRL_RESET    = 4'h0;
  localparam logic [3:0] ICU_RESET     = 4'h0;

  // Last step of the bit counter per mode
  localparam logic [3:0] SYNC_STEP_LAST    = 4'h3;
  localparam logic [3:0] ASYNC_STEP_LAST16 = 4'hF;
  localparam logic [3:0] ASYNC_STEP_LAST8  = 4'h7;

  // Status flags, overrun in bit 0
  typedef struct packed {
    logic transmitEndFlag;
    logic transmitBufferEmptyFlag;
    logic receiveBufferFullFlag;
    logic parityErrorFlag;
    logic framingErrorFlag;
    logic overrunErrorFlag;
  } sbr_flags_type;

  // Rate settings
  typedef struct packed {
    logic       asyncMode;
    logic [1:0] prescaleExp;
    logic       doubleSpeedSelect;
    logic       baseClockSelect;
    logic [7:0] divider;
  } sbr_rate_cfg_type;

  // Last count of the prescaler: 4^n - 1
  function automatic logic [5:0] prescaleLast(input logic [1:0] n);
    logic [6:0] one;
    one = 7'h01;
    return 6'((one << {n, 1'b0}) - one);
  endfunction

endpackage

/* File: core/sbr_rate_counter.sv */
`timescale 1ns/10ps
module sbr_rate_counter
  import sbr_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Settings
  input  wire logic       runEnable,
  input  wire logic [1:0] prescaleExp,
  input  wire logic [7:0] divider,
  // Base clock pulse
  output logic            baseTick
);

  logic [5:0] presCnt_q;
  logic [7:0] divCnt_q;
  logic [7:0] limit_q;
  logic       baseTick_q;
  logic       presTick;
  logic       divWrap;

  // Prescaler ends every 4^n cycles
  assign presTick = (presCnt_q >= prescaleLast(prescaleExp));
  assign divWrap  = presTick && (divCnt_q >= limit_q);

  // Prescaler count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      presCnt_q <= 6'h00;
    end else if (!runEnable || presTick) begin
      presCnt_q <= 6'h00;
    end else begin
      presCnt_q <= 6'(presCnt_q + 6'h01);
    end
  end

  // Divider count with reload of the setting on each wrap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= 8'h00;
      limit_q  <= DIVIDER_RESET;
    end else if (!runEnable) begin
      divCnt_q <= 8'h00;
      limit_q  <= divider;
    end else if (divWrap) begin
      divCnt_q <= 8'h00;
      limit_q  <= divider;
    end else if (presTick) begin
      divCnt_q <= 8'(divCnt_q + 8'h01);
    end
  end

  // One pulse per wrap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      baseTick_q <= 1'b0;
    end else begin
      baseTick_q <= runEnable && divWrap;
    end
  end

  assign baseTick = baseTick_q;

endmodule

/* File: bench/sbr_cpu_model.sv */
`timescale 1ns/10ps
module sbr_cpu_model
  import sbr_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Requests from the serial block
  input  wire logic [3:0] irqRequest,
  // Processor state
  input  wire logic       cpuGlobalInterruptMask,
  input  wire logic [3:0] icuPriorityLevel,
  // Acceptance
  output logic [3:0]      accepted,
  output logic [7:0]      acceptedVector
);
  // Accept only with global flag set and a nonzero priority
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      accepted <= 4'h0;
    end else begin
      accepted <= irqRequest &
                  {4{cpuGlobalInterruptMask && (icuPriorityLevel != 4'h0)}};
    end
  end

  // Lowest accepted request picks the vector
  always_comb begin
    acceptedVector = 8'h00;
    for (int i = 3; i >= 0; i--) begin
      if (accepted[i]) begin
        acceptedVector = 8'(VECTOR_ERR + i);
      end
    end
  end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/10ps
module tb
  import sbr_pkg::*;
;
  logic          core_clk;
  logic          rst_n;
  logic [4:0]    address;
  logic [3:0]    byteenable;
  logic          read;
  logic          write;
  logic [31:0]   writedata;
  logic [31:0]   readdata;
  logic          waitrequest;
  sbr_flags_type flagSet;
  sbr_flags_type flags;
  logic          baseClockTick;
  logic          bitTick;
  logic [3:0]    irqRequest;
  logic          irq;
  logic          cpuGlobalInterruptMask;
  logic [3:0]    icuPriorityLevel;
  logic [3:0]    accepted;
  logic [7:0]    acceptedVector;
  logic [31:0]   rd;
  int            miscompares;
  int            samplesChecked;
  int            parity_error_flag;
  int            j;

  // Design and far-side model
  sbr_core u_sbr_core (
    .core_clk(core_clk), .rst_n(rst_n), .address(address), .byteenable(byteenable),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .flagSet(flagSet), .flags(flags),
    .baseClockTick(baseClockTick), .bitTick(bitTick), .irqRequest(irqRequest), .irq(irq)
  );
  sbr_cpu_model u_sbr_cpu_model (
    .core_clk(core_clk), .rst_n(rst_n), .irqRequest(irqRequest),
    .cpuGlobalInterruptMask(cpuGlobalInterruptMask), .icuPriorityLevel(icuPriorityLevel),
    .accepted(accepted), .acceptedVector(acceptedVector)
  );

  // Verdict and end of run
  task summarize;
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compare one value
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Wait for the slave answer, bounded
  task waitAck;
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 200);
    if (waitrequest !== 1'b0) begin
      miscompares++;
      summarize();
    end
  endtask

  // Avalon write, released after the accepting edge
  task busWrite(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    write      <= 1'b1;
    waitAck();
    write <= 1'b0;
    @(posedge core_clk);
  endtask

  // Avalon read, data taken at the accepting edge
  task busRead(input logic [4:0] a, output logic [31:0] d);
    address <= a;
    read    <= 1'b1;
    waitAck();
    d = readdata;
    read <= 1'b0;
    @(posedge core_clk);
  endtask

  // One-cycle flag set pulse, then let requests settle
  task pulse(input logic [5:0] v);
    flagSet <= v;
    @(posedge core_clk);
    flagSet <= '0;
    repeat (5) @(posedge core_clk);
  endtask

  // Period in cycles between two pulses, skipping the first ones
  task measure(input logic useBit, output int p);
    int seen;
    logic s;
    p = 0;
    seen = 0;
    for (int k = 0; k < 20000 && seen < 4; k++) begin
      @(posedge core_clk);
      s = useBit ? bitTick : baseClockTick;
      if (seen >= 3) p++;
      if (s === 1'b1) seen++;
    end
    if (seen < 4) begin
      miscompares++;
      summarize();
    end
  endtask

  // Program a rate setting and check both tick periods
  task runRate(input logic [2:0] m, input logic [1:0] e, input logic [7:0] d);
    int p;
    int bitExp;
    int baseExp;
    p = (4 ** int'(m[1:0])) * (int'(d) + 1);
    bitExp = 4 * p;
    baseExp = p;
    if (m[2]) begin
      bitExp = (e == 2'h3) ? 8 * p : ((e == 2'h0) ? 32 * p : 16 * p);
      baseExp = e[0] ? p : 2 * p;
    end
    busWrite(ADDR_SERIAL_CONTROL_REG, 32'h0000_0000, 4'hF);
    busWrite(ADDR_SERIAL_MODE_REG, {29'h0, m}, 4'hF);
    busWrite(ADDR_EXTENDED_MODE_REG, {30'h0, e}, 4'hF);
    busWrite(ADDR_BIT_RATE_DIVIDER, {24'h0, d}, 4'hF);
    busWrite(ADDR_SERIAL_CONTROL_REG, 32'h0000_0008, 4'hF);
    measure(1'b1, parity_error_flag);
    check(32'(parity_error_flag), 32'(bitExp));
    measure(1'b0, parity_error_flag);
    check(32'(parity_error_flag), 32'(baseExp));
  endtask

  // Bench clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    address = 5'h00;
    byteenable = 4'hF;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    flagSet = '0;
    cpuGlobalInterruptMask = 1'b1;
    icuPriorityLevel = 4'h1;
    miscompares = 0;
    samplesChecked = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // Reset values, unmapped place included
    for (int i = 0; i < 8; i++) begin
      busRead(5'(i * 4), rd);
      check(rd, (i == 2) ? 32'h0000_00FF : 32'h0000_0000);
    end
    busWrite(5'h1C, 32'h0000_FFFF, 4'hF);
    busRead(5'h1C, rd);
    check(rd, 32'h0000_0000);
    busWrite(ADDR_BIT_RATE_DIVIDER, 32'h0000_0012, 4'hE);
    busRead(ADDR_BIT_RATE_DIVIDER, rd);
    check(rd, 32'h0000_00FF);
    // Rate settings across modes, prescalers and divider ends
    runRate(3'h0, 2'h0, 8'h00);
    runRate(3'h1, 2'h0, 8'h00);
    runRate(3'h2, 2'h0, 8'h00);
    runRate(3'h3, 2'h0, 8'h00);
    runRate(3'h0, 2'h0, 8'hFF);
    runRate(3'h0, 2'h3, 8'h01);
    runRate(3'h4, 2'h0, 8'h01);
    runRate(3'h4, 2'h1, 8'h01);
    runRate(3'h4, 2'h2, 8'h01);
    runRate(3'h4, 2'h3, 8'h01);
    runRate(3'h5, 2'h0, 8'h00);
    // Each flag raises its request and is accepted
    busWrite(ADDR_ICU_SOURCE_ENABLE, 32'h0000_000F, 4'hF);
    busWrite(ADDR_SERIAL_CONTROL_REG, 32'h0000_0007, 4'hF);
    for (int i = 0; i < 6; i++) begin
      pulse(6'(1 << i));
      check({26'h0, flags}, 32'(1 << i));
      j = (i < 3) ? 0 : i - 2;
      check({28'h0, irqRequest}, 32'(1 << j));
      check({31'h0, irq}, 32'h0000_0001);
      check({28'h0, accepted}, 32'(1 << j));
      check({24'h0, acceptedVector}, 32'(VECTOR_ERR + j));
      busRead(ADDR_SERIAL_STATUS_REG, rd);
      check(rd, 32'(1 << i));
      busWrite(ADDR_SERIAL_STATUS_REG, 32'h0000_0000, 4'hF);
      busWrite(ADDR_ICU_REQUEST_FLAG, 32'h0000_000F, 4'hF);
      repeat (3) @(posedge core_clk);
      check({27'h0, irqRequest, irq}, 32'h0000_0000);
    end
    // Local enable gates, controller mask, global flag
    busWrite(ADDR_SERIAL_CONTROL_REG, 32'h0000_0000, 4'hF);
    pulse(6'h08);
    check({28'h0, irqRequest}, 32'h0000_0000);
    busWrite(ADDR_SERIAL_CONTROL_REG, 32'h0000_0001, 4'hF);
    repeat (4) @(posedge core_clk);
    check({28'h0, irqRequest}, 32'h0000_0002);
    busWrite(ADDR_ICU_SOURCE_ENABLE, 32'h0000_0000, 4'hF);
    repeat (3) @(posedge core_clk);
    check({27'h0, irqRequest, irq}, 32'h0000_0000);
    busRead(ADDR_ICU_REQUEST_FLAG, rd);
    check(rd, 32'h0000_0002);
    cpuGlobalInterruptMask <= 1'b0;
    busWrite(ADDR_ICU_SOURCE_ENABLE, 32'h0000_000F, 4'hF);
    repeat (3) @(posedge core_clk);
    check({28'h0, accepted}, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0001);
    cpuGlobalInterruptMask <= 1'b1;
    icuPriorityLevel <= 4'h0;
    repeat (3) @(posedge core_clk);
    check({28'h0, accepted}, 32'h0000_0000);
    icuPriorityLevel <= 4'h1;
    repeat (3) @(posedge core_clk);
    check({28'h0, accepted}, 32'h0000_0002);
    busWrite(ADDR_SERIAL_CONTROL_REG, 32'h0000_0003, 4'hF);
    pulse(6'h20);
    check({28'h0, irqRequest}, 32'h0000_0002);
    // Error flag needs a read of one before a clearing write
    busWrite(ADDR_SERIAL_STATUS_REG, 32'h0000_0000, 4'hF);
    busWrite(ADDR_ICU_REQUEST_FLAG, 32'h0000_000F, 4'hF);
    pulse(6'h01);
    busWrite(ADDR_SERIAL_STATUS_REG, 32'h0000_0000, 4'hF);
    busRead(ADDR_SERIAL_STATUS_REG, rd);
    check(rd, 32'h0000_0001);
    busWrite(ADDR_SERIAL_STATUS_REG, 32'h0000_0000, 4'hF);
    busRead(ADDR_SERIAL_STATUS_REG, rd);
    check(rd, 32'h0000_0000);
    summarize();
  end
endmodule
